//--- design/adc_serial_out.v
// serial output and direct-pin control of a dual 12-bit converter
// assumes pins and sample data arrive asynchronously to clk_sys;
// the APB master runs on clk_sys
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "adc_ser_defines.vh"

module adc_serial_out (
  input wire clk_sys,
  input wire rst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // converter core and pins
  input wire sample_clk,
  input wire [11:0] sample_a,
  input wire [11:0] sample_b,
  input wire dll_restart,
  input wire serial_ctrl_select,
  input wire [1:0] format_stabilizer_select,
  input wire sleep_request_chan_a,
  input wire sleep_request_chan_b,
  input wire test_pattern_select,
  input wire word_align_select,
  input wire lane_count_select,
  // status toward the core
  output reg duty_stabilizer_on,
  output reg chan_a_powered_down,
  output reg chan_b_powered_down,
  output reg timing_locked,
  // serial link
  output reg forwarded_bit_clock,
  output reg word_frame,
  output reg lane1_chan_a,
  output reg lane1_chan_b,
  output reg lane0_chan_a,
  output reg lane0_chan_b,
  output reg lane0_chan_a_oe,
  output reg lane0_chan_b_oe
);

  localparam SYNC_W = 34;
  localparam integer LOCK_CYC_I = `LOCK_CYC;
  localparam integer HALF_CYC_I = `HALF_BIT_CYC;
  // counts cut to the counter widths on purpose
  localparam [9:0] LOCK_CNT = LOCK_CYC_I[9:0];
  localparam [3:0] HALF_CNT = HALF_CYC_I[3:0];

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire [SYNC_W-1:0] pin_raw;
  reg [SYNC_W-1:0] pin_meta_ff;
  reg [SYNC_W-1:0] pin_sync_ff;

  assign pin_raw = {sample_b, sample_a, lane_count_select, word_align_select,
                    test_pattern_select, sleep_request_chan_b,
                    sleep_request_chan_a, format_stabilizer_select,
                    serial_ctrl_select, dll_restart, sample_clk};

  // two flops per pin bit
  // sample word shares the clock's stages, so edge and data line up
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          pin_meta_ff[gi] <= 1'b0;
          pin_sync_ff[gi] <= 1'b0;
        end else begin
          pin_meta_ff[gi] <= pin_raw[gi];
          pin_sync_ff[gi] <= pin_meta_ff[gi];
        end
      end
    end
  endgenerate

  wire smp_clk_s = pin_sync_ff[0];
  wire restart_s = pin_sync_ff[1];
  wire ser_sel_s = pin_sync_ff[2];
  wire [6:0] pin_ctrl = pin_sync_ff[9:3];
  wire [11:0] smp_a_s = pin_sync_ff[21:10];
  wire [11:0] smp_b_s = pin_sync_ff[33:22];

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  reg [6:0] ctrl_ff;
  wire [31:0] stat_word;
  reg [31:0] rd_mux;
  wire acc = psel & penable;
  wire hit_ctrl = (paddr == `ADDR_CTRL);
  wire hit_stat = (paddr == `ADDR_STAT);

  assign pready = 1'b1;
  // unmapped addresses answer with an error and read zero
  assign pslverr = acc & ~(hit_ctrl | hit_stat);

  // control register write
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= `CTRL_RST;
    end else if (acc & pwrite & hit_ctrl) begin
      ctrl_ff <= pwdata[6:0];
    end
  end

  // read mux, unmapped reads zero
  always @* begin
    rd_mux = 32'h0;
    if (hit_ctrl) begin
      rd_mux = {25'h0, ctrl_ff};
    end else if (hit_stat) begin
      rd_mux = stat_word;
    end
  end

  // read data snapped in setup phase, held through access
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel & ~penable) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // setting selection and decode
  // ----------------------------------------------------------------
  // registers override pins when serial_ctrl_select is high
  wire [6:0] eff = ser_sel_s ? ctrl_ff : pin_ctrl;
  wire [1:0] fmt = eff[`CTRL_FMT_MSB:`CTRL_FMT_LSB];
  wire twos = fmt[1];
  wire dcs = fmt[1] ^ fmt[0];
  wire sleep_a = eff[`CTRL_SLEEP_A];
  wire sleep_b = eff[`CTRL_SLEEP_B];
  wire test_on = eff[`CTRL_TEST];
  wire single = eff[`CTRL_LANES];
  wire aligned = eff[`CTRL_ALIGN] & ~single;
  // device power-down needs both channels asleep
  wire dev_sleep = sleep_a & sleep_b;

  assign stat_word = {25'h0, single, twos, dcs, ser_sel_s, chan_b_powered_down,
                      chan_a_powered_down, timing_locked};

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      duty_stabilizer_on <= 1'b0;
      chan_a_powered_down <= 1'b0;
      chan_b_powered_down <= 1'b0;
    end else begin
      duty_stabilizer_on <= dcs;
      chan_a_powered_down <= sleep_a;
      chan_b_powered_down <= sleep_b;
    end
  end

  // ----------------------------------------------------------------
  // timing loop restart
  // ----------------------------------------------------------------
  reg [9:0] lock_cnt_ff;

  // counter parks at its end value; lock holds until next restart
  // relock interval after restart
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_ff <= 10'h0;
      timing_locked <= 1'b0;
    end else if (restart_s) begin
      lock_cnt_ff <= 10'h0;
      timing_locked <= 1'b0;
    end else if (lock_cnt_ff != LOCK_CNT) begin
      lock_cnt_ff <= lock_cnt_ff + 10'h1;
      timing_locked <= 1'b0;
    end else begin
      timing_locked <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sample capture
  // ----------------------------------------------------------------
  reg smp_prev_ff;
  reg pick_ff;
  reg [11:0] hold1_ff [0:1];
  reg [11:0] hold0_ff [0:1];
  wire smp_edge = smp_clk_s & ~smp_prev_ff;
  wire [1:0] ch_awake = {~sleep_b, ~sleep_a};
  wire [11:0] raw [0:1];

  assign raw[0] = smp_a_s;
  assign raw[1] = smp_b_s;

  // sample clock edge and lane toggle
  // single lane parks the toggle so dual lane restarts on lane 1
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      smp_prev_ff <= 1'b0;
      pick_ff <= 1'b0;
    end else begin
      smp_prev_ff <= smp_clk_s;
      if (smp_edge & ~single) begin
        pick_ff <= ~pick_ff;
      end else if (single) begin
        pick_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // bit clock and frame
  // ----------------------------------------------------------------
  reg [3:0] div_ff;
  reg [3:0] idx_ff;
  wire bit_ev = ~dev_sleep & (div_ff == 4'h0);
  wire start1 = bit_ev & (idx_ff == 4'h0);
  wire start0 = bit_ev & (idx_ff == (aligned ? 4'h0 : `HALF_WORD));

  // power-down parks divider and index so wake starts a fresh word
  // clocks low in power-down
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 4'h0;
      idx_ff <= 4'h0;
      forwarded_bit_clock <= 1'b0;
      word_frame <= 1'b0;
    end else if (dev_sleep) begin
      div_ff <= 4'h0;
      idx_ff <= 4'h0;
      forwarded_bit_clock <= 1'b0;
      word_frame <= 1'b0;
    end else begin
      div_ff <= (div_ff == 4'h0) ? HALF_CNT - 4'h1 : div_ff - 4'h1;
      if (bit_ev) begin
        forwarded_bit_clock <= ~forwarded_bit_clock;
        idx_ff <= (idx_ff == `WORD_BITS - 4'h1) ? 4'h0 : idx_ff + 4'h1;
        if (idx_ff == 4'h0) begin
          word_frame <= 1'b1;
        end else if (idx_ff == `HALF_WORD) begin
          word_frame <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // per-channel serializers
  // ----------------------------------------------------------------
  reg [11:0] sh1_ff [0:1];
  reg [11:0] sh0_ff [0:1];
  reg [1:0] l1_ff;
  reg [1:0] l0_ff;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      wire [11:0] conv = {raw[ch][11] ^ twos, raw[ch][10:0]};
      // test word bypasses the format conversion
      // test word replaces data
      wire [11:0] word = test_on ? `TEST_WORD : conv;

      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          hold1_ff[ch] <= 12'h0;
          hold0_ff[ch] <= 12'h0;
        end else if (smp_edge & ch_awake[ch]) begin
          if (single | ~pick_ff) begin
            hold1_ff[ch] <= word;
          end else begin
            hold0_ff[ch] <= word;
          end
        end
      end

      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          sh1_ff[ch] <= 12'h0;
          sh0_ff[ch] <= 12'h0;
          l1_ff[ch] <= 1'b0;
          l0_ff[ch] <= 1'b0;
        end else if (bit_ev & ch_awake[ch]) begin
          if (start1) begin
            l1_ff[ch] <= hold1_ff[ch][11];
            sh1_ff[ch] <= {hold1_ff[ch][10:0], 1'b0};
          end else begin
            l1_ff[ch] <= sh1_ff[ch][11];
            sh1_ff[ch] <= {sh1_ff[ch][10:0], 1'b0};
          end
          if (single) begin
            l0_ff[ch] <= l0_ff[ch];
          end else if (start0) begin
            l0_ff[ch] <= hold0_ff[ch][11];
            sh0_ff[ch] <= {hold0_ff[ch][10:0], 1'b0};
          end else begin
            l0_ff[ch] <= sh0_ff[ch][11];
            sh0_ff[ch] <= {sh0_ff[ch][10:0], 1'b0};
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // lane outputs
  // ----------------------------------------------------------------
  // lane 0 level kept in single lane; only its enable drops
  // lane 0 released in single lane
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lane0_chan_a_oe <= 1'b0;
      lane0_chan_b_oe <= 1'b0;
    end else begin
      lane0_chan_a_oe <= ~single;
      lane0_chan_b_oe <= ~single;
    end
  end

  // data pins straight from lane flops
  always @* begin
    lane1_chan_a = l1_ff[0];
    lane1_chan_b = l1_ff[1];
    lane0_chan_a = l0_ff[0];
    lane0_chan_b = l0_ff[1];
  end

endmodule // adc_serial_out

//--- inc/adc_ser_defines.vh
// constants of the dual-channel serial output block
// assumes a 100 MHz system clock and a 32-bit APB register bus
`ifndef ADC_SER_DEFINES_VH
`define ADC_SER_DEFINES_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ADDR_CTRL 12'h000
`define ADDR_STAT 12'h004
`define CTRL_FMT_LSB 0
`define CTRL_FMT_MSB 1
`define CTRL_SLEEP_A 2
`define CTRL_SLEEP_B 3
`define CTRL_TEST 4
`define CTRL_ALIGN 5
`define CTRL_LANES 6
`define CTRL_RST 7'h03
`define STAT_LOCKED 0
`define STAT_SLEEP_A 1
`define STAT_SLEEP_B 2
`define STAT_SER_SEL 3
`define STAT_DCS 4
`define STAT_TWOS 5
`define STAT_SINGLE 6

// ----------------------------------------------------------------
// data and timing
// ----------------------------------------------------------------
`define TEST_WORD 12'ha63
`define WORD_BITS 4'hc
`define HALF_WORD 4'h6
`define CLK_PERIOD_NS 10
`define HALF_BIT_NS 40
`define HALF_BIT_CYC ((`HALF_BIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCK_TIME_NS 5000
`define LOCK_CYC ((`LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- test/adc_serial_props.sv
// checker for the serial link and pin decode of adc_serial_out
// assumes one clk_sys domain and rst_n asynchronous, active low
`timescale 1ns/1ns
module adc_serial_props (
  input wire clk_sys,
  input wire rst_n,
  input wire serial_ctrl_select,
  input wire [1:0] format_stabilizer_select,
  input wire sleep_request_chan_a,
  input wire sleep_request_chan_b,
  input wire lane_count_select,
  input wire dll_restart,
  input wire duty_stabilizer_on,
  input wire chan_a_powered_down,
  input wire chan_b_powered_down,
  input wire timing_locked,
  input wire forwarded_bit_clock,
  input wire word_frame,
  input wire lane1_chan_a,
  input wire lane1_chan_b,
  input wire lane0_chan_a_oe,
  input wire lane0_chan_b_oe
);
  // device asleep means both channels down
  wire dev_pd = chan_a_powered_down && chan_b_powered_down;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // direct pin decode
  // ----------------------------------------
  fmt_decode_a: assert property (
    (!serial_ctrl_select && $stable(format_stabilizer_select))[*6]
    |-> duty_stabilizer_on == ^format_stabilizer_select) else $error("stabilizer decode wrong");
  sleep_decode_a: assert property (
    (!serial_ctrl_select && $stable({sleep_request_chan_a, sleep_request_chan_b}))[*6]
    |-> chan_a_powered_down == sleep_request_chan_a
    && chan_b_powered_down == sleep_request_chan_b) else $error("sleep decode wrong");
  lane0_off_a: assert property (
    (!serial_ctrl_select && lane_count_select)[*6]
    |-> !lane0_chan_a_oe && !lane0_chan_b_oe) else $error("lane 0 driven in single lane");
  // ----------------------------------------
  // link timing
  // ----------------------------------------
  bit_hold_a: assert property (disable iff (!rst_n || dev_pd)
    $changed(forwarded_bit_clock) |=> $stable(forwarded_bit_clock)[*3])
    else $error("bit clock half period wrong");
  data_edge_a: assert property (disable iff (!rst_n || dev_pd)
    $changed({lane1_chan_a, lane1_chan_b, word_frame}) |-> $changed(forwarded_bit_clock))
    else $error("lane or frame moved off a bit edge");
  frame_width_a: assert property (disable iff (!rst_n || dev_pd)
    $rose(word_frame) |-> ##24 $fell(word_frame)) else $error("frame high time wrong");
  pd_quiet_a: assert property (
    dev_pd[*3] |-> !forwarded_bit_clock && !word_frame) else $error("clock runs in power-down");
  freeze_a: assert property (
    chan_a_powered_down[*3] |-> $stable(lane1_chan_a)) else $error("lane moved while asleep");
  restart_clear_a: assert property (
    $rose(dll_restart) |-> ##[1:5] !timing_locked) else $error("restart kept lock");
  relock_time_a: assert property (
    $fell(dll_restart) |=> !timing_locked[*8] ##[480:515] timing_locked)
    else $error("relock time wrong");
endmodule // adc_serial_props

bind adc_serial_out adc_serial_props u_props (.clk_sys, .rst_n, .serial_ctrl_select,
  .format_stabilizer_select, .sleep_request_chan_a, .sleep_request_chan_b, .lane_count_select,
  .dll_restart, .duty_stabilizer_on, .chan_a_powered_down, .chan_b_powered_down,
  .timing_locked, .forwarded_bit_clock, .word_frame, .lane1_chan_a, .lane1_chan_b,
  .lane0_chan_a_oe, .lane0_chan_b_oe);

//--- test/lane_receiver.sv
// far-side receiver model: rebuilds 12-bit words of one channel
// assumes clk_sys oversamples the bit clock, four cycles per edge
`timescale 1ns/1ns
module lane_receiver (
  input wire clk_sys,
  input wire rst_n,
  input wire forwarded_bit_clock,
  input wire word_frame,
  input wire lane1,
  input wire lane0,
  input wire word_align_select,
  output logic [11:0] word1_ff,
  output logic [11:0] word0_ff,
  output logic [7:0] count_ff
);
  logic bclk_ff;
  logic frame_ff;
  logic [11:0] sh1_ff;
  logic [11:0] sh0_ff;
  wire rise = word_frame && !frame_ff;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bclk_ff <= 1'b0;
      frame_ff <= 1'b0;
      count_ff <= 8'h00;
    end else if (forwarded_bit_clock != bclk_ff) begin
      bclk_ff <= forwarded_bit_clock;
      frame_ff <= word_frame;
      sh1_ff <= {sh1_ff[10:0], lane1};
      sh0_ff <= {sh0_ff[10:0], lane0};
      if (rise) begin
        word1_ff <= sh1_ff;
        count_ff <= count_ff + 8'h01;
      end
      if (word_align_select ? rise : (frame_ff && !word_frame))
        word0_ff <= sh0_ff;
    end
  end
endmodule // lane_receiver

//--- test/tb_top.sv
// testbench: pins, sample stream and APB traffic for adc_serial_out
// assumes the lane receiver model and the bound checker
`timescale 1ns/1ns
`include "adc_ser_defines.vh"
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sample_clk = 1'b0, flip = 1'b0;
  logic dll_restart = 1'b0, serial_ctrl_select = 1'b0, test_pattern_select = 1'b0;
  logic sleep_request_chan_a = 1'b0, sleep_request_chan_b = 1'b0;
  logic word_align_select = 1'b0, lane_count_select = 1'b0, err, hold;
  logic [1:0] format_stabilizer_select = 2'h0;
  logic [3:0] div = 4'h0;
  logic [11:0] paddr = 12'h000, base_a = 12'h8a1, base_b = 12'h35e, ea, eb;
  logic [31:0] pwdata = 32'h0, rd;
  int fail_count = 0, n_tests = 0, k;
  wire pready, pslverr, duty_stabilizer_on, chan_a_powered_down, chan_b_powered_down;
  wire timing_locked, forwarded_bit_clock, word_frame, lane1_chan_a, lane1_chan_b;
  wire lane0_chan_a, lane0_chan_b, lane0_chan_a_oe, lane0_chan_b_oe;
  wire [31:0] prdata;
  wire [11:0] sample_a = base_a ^ {12{flip}};
  wire [11:0] sample_b = base_b ^ {12{flip}};
  wire [11:0] w1a, w0a, w1b, w0b;
  wire [7:0] ca;
  wire l0a = lane0_chan_a_oe ? lane0_chan_a : 1'bz;
  wire l0b = lane0_chan_b_oe ? lane0_chan_b : 1'bz;

  adc_serial_out u_dut (.*);
  lane_receiver rx_a (.clk_sys, .rst_n, .forwarded_bit_clock, .word_frame, .lane1(lane1_chan_a),
    .lane0(l0a), .word_align_select, .word1_ff(w1a), .word0_ff(w0a), .count_ff(ca));
  lane_receiver rx_b (.clk_sys, .rst_n, .forwarded_bit_clock, .word_frame, .lane1(lane1_chan_b),
    .lane0(l0b), .word_align_select, .word1_ff(w1b), .word0_ff(w0b), .count_ff());

  // ----------------------------------------
  // clock, sample clock, shared tasks
  // ----------------------------------------
  initial forever #5 clk_sys = !clk_sys;
  always @(posedge clk_sys) begin
    div <= (div == 4'hb) ? 4'h0 : div + 4'h1;
    if (div == 4'hb) sample_clk <= !sample_clk;
    if (div == 4'hb && sample_clk) flip <= !flip;
  end
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task words(input int n);
    repeat (n) @(ca);
    @(posedge clk_sys);
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    stop_test;
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h3);
    for (k = 0; k < 4; k++) begin
      format_stabilizer_select <= k[1:0];
      words(4);
      ea = {base_a[11] ^ k[1], base_a[10:0]};
      eb = {base_b[11] ^ k[1], base_b[10:0]};
      chk("lane1 a", w1a === ea || w1a === ~ea, 1);
      chk("lane1 b", w1b === eb || w1b === ~eb, 1);
      chk("pair a", w1a ^ w0a, 12'hfff);
      chk("pair b", w1b ^ w0b, 12'hfff);
      chk("stabilizer", duty_stabilizer_on, ^k[1:0]);
    end
    $display("formats done");
    test_pattern_select <= 1'b1;
    words(4);
    chk("test a", w1a, 12'ha63);
    chk("test b0", w0b, 12'ha63);
    test_pattern_select <= 1'b0;
    word_align_select <= 1'b1;
    words(4);
    chk("aligned", w1a ^ w0a, 12'hfff);
    word_align_select <= 1'b0;
    lane_count_select <= 1'b1;
    words(4);
    chk("oe a", lane0_chan_a_oe, 0);
    chk("oe b", lane0_chan_b_oe, 0);
    chk("single a", w1a === ea || w1a === ~ea, 1);
    $display("lanes done");
    serial_ctrl_select <= 1'b1;
    apb(1'b1, `ADDR_CTRL, 32'h13);
    words(4);
    chk("reg test", w1a, 12'ha63);
    chk("reg dual", lane0_chan_b_oe, 1);
    apb(1'b0, `ADDR_STAT, 32'h0);
    chk("status", rd[6:3], 4'h5);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", err, 1);
    chk("unmapped data", rd, 0);
    $display("registers done");
    serial_ctrl_select <= 1'b0;
    sleep_request_chan_a <= 1'b1;
    repeat (8) @(posedge clk_sys);
    hold = lane1_chan_a;
    words(4);
    chk("a frozen", lane1_chan_a, hold);
    chk("b awake", chan_b_powered_down, 0);
    chk("b runs", w1b === eb || w1b === ~eb, 1);
    sleep_request_chan_b <= 1'b1;
    repeat (60) @(posedge clk_sys);
    chk("asleep", chan_a_powered_down, 1);
    chk("quiet", {forwarded_bit_clock, word_frame}, 0);
    hold = lane1_chan_a;
    repeat (60) @(posedge clk_sys);
    chk("frozen", lane1_chan_a, hold);
    sleep_request_chan_a <= 1'b0;
    sleep_request_chan_b <= 1'b0;
    $display("power-down done");
    dll_restart <= 1'b1;
    repeat (100) @(posedge clk_sys);
    chk("unlocked", timing_locked, 0);
    dll_restart <= 1'b0;
    repeat (400) @(posedge clk_sys);
    chk("still unlocked", timing_locked, 0);
    repeat (160) @(posedge clk_sys);
    chk("relocked", timing_locked, 1);
    $display("restart done");
    stop_test;
  end
endmodule // tb_top
